/* rtl/swr_pkg.sv */
/*
 * Shared constants and types for the single-wire ROM and read-memory
 * command layer. Assumes a slot timing generator outside the block.
 */
package swr_pkg;
	// ROM function command codes.
	localparam logic [7:0] ROM_READ     = 8'h33;
	localparam logic [7:0] ROM_MATCH    = 8'h55;
	localparam logic [7:0] ROM_SEARCH   = 8'hF0;
	localparam logic [7:0] ROM_SKIP     = 8'hCC;
	localparam logic [7:0] ROM_RESUME   = 8'hA5;
	localparam logic [7:0] ROM_OD_SKIP  = 8'h3C;
	localparam logic [7:0] ROM_OD_MATCH = 8'h69;
	// Memory function command codes.
	localparam logic [7:0] MEM_READ     = 8'hF0;
	localparam logic [7:0] MEM_READ_EXT = 8'hA5;
	// Memory map, fill value and page layout.
	localparam logic [15:0] MEM_TOP     = 16'h0A3F;
	localparam int          MEM_BYTES   = 2624;
	localparam logic [7:0]  FILL_BYTE   = 8'hFF;
	localparam logic [4:0]  PAGE_LAST   = 5'h1F;
	// Reflected form of x16 + x15 + x2 + 1.
	localparam logic [15:0] CRC16_POLY  = 16'hA001;
	// Registration number length in bits and bytes.
	localparam logic [6:0]  ROM_BITS    = 7'h40;
	localparam logic [3:0]  ROM_BYTES   = 4'h8;
	// Transmit FIFO shape.
	localparam int          FIFO_WIDTH  = 8;
	localparam int          FIFO_DEPTH  = 16;

	// Command layer states, one-hot.
	typedef enum logic [9:0] {
		ST_IDLE   = 10'h001,
		ST_ROMCMD = 10'h002,
		ST_MATCH  = 10'h004,
		ST_SEARCH = 10'h008,
		ST_TXROM  = 10'h010,
		ST_MEMCMD = 10'h020,
		ST_ADDR   = 10'h040,
		ST_READ   = 10'h080,
		ST_HALT   = 10'h100,
		ST_SPARE  = 10'h200
	} swr_state_t;
endpackage : swr_pkg

/* rtl/swr_fifo_if.sv */
/*
 * Carrier between the command layer and its transmit FIFO.
 * Assumes both ends share one clock.
 */
`timescale 1ns/1ps
`default_nettype none
interface swr_fifo_if #(parameter int W = 8);
	logic         wvalid;  // Producer offers a word.
	logic         wready;  // FIFO has room.
	logic [W-1:0] wdata;   // Word offered.
	logic         rvalid;  // FIFO holds a word.
	logic         rready;  // Consumer takes the word.
	logic [W-1:0] rdata;   // Oldest word.
	logic         flush;   // Drop all contents.
	modport buffer (input wvalid, wdata, rready, flush, output wready, rvalid, rdata);
	modport user   (output wvalid, wdata, rready, flush, input wready, rvalid, rdata);
endinterface : swr_fifo_if
`default_nettype wire

/* rtl/swr_fifo.sv */
/*
 * Synchronous FIFO with valid and ready on both sides and a flush.
 * Assumes one clock, a clock enable and an active-low async reset.
 */
`timescale 1ns/1ps
`default_nettype none
module swr_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
) (
	// Clock, reset and enable.
	input  wire logic clk_i,
	input  wire logic arst_n_i,
	input  wire logic ce_i,
	// FIFO port.
	swr_fifo_if.buffer f
);
	localparam int AW = $clog2(DEPTH);

	// Pointers are one bit wider than the index so full and empty differ.
	typedef struct packed {
		logic [AW:0] wptr;
		logic [AW:0] rptr;
	} swr_fifo_st_t;

	swr_fifo_st_t     s;        // Registered pointers.
	swr_fifo_st_t     next_s;   // Next pointers.
	logic [WIDTH-1:0] mem [DEPTH];  // Word storage.
	logic             full;     // No room left.
	logic             empty;    // Nothing held.

	// Power-of-two depths only, so pointer wrap is a plain carry.
	if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_chk
		$error("swr_fifo: DEPTH must be a power of two of at least 2");
	end

	assign empty    = (s.wptr == s.rptr);
	assign full     = (s.wptr[AW] != s.rptr[AW]) && (s.wptr[AW-1:0] == s.rptr[AW-1:0]);
	assign f.wready = !full;
	assign f.rvalid = !empty;
	assign f.rdata  = mem[s.rptr[AW-1:0]];

	// Pointer update; a flush wins over any transfer in the same cycle.
	always_comb begin
		next_s = s;
		if (f.flush) begin
			next_s.wptr = '0;
			next_s.rptr = '0;
		end else begin
			if (f.wvalid && !full) begin
				next_s.wptr = s.wptr + 1'b1;
			end
			if (f.rready && !empty) begin
				next_s.rptr = s.rptr + 1'b1;
			end
		end
	end

	// State register, frozen while the enable is low.
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			s <= '0;
		end else if (ce_i) begin
			s <= next_s;
		end
	end

	// Storage write; contents need no reset since pointers guard them.
	always_ff @(posedge clk_i) begin
		if (ce_i && f.wvalid && !full && !f.flush) begin
			mem[s.wptr[AW-1:0]] <= f.wdata;
		end
	end
endmodule : swr_fifo
`default_nettype wire

/* rtl/swr_top.sv */
/*
 * Command layer of a single-wire EEPROM slave: ROM functions and the
 * two read memory functions, with a transmit FIFO on the data path.
 * Assumes a slot timing generator on clk_i that reports reset pulses
 * and slots as one-cycle pulses and times the line itself.
 */
`timescale 1ns/1ps
`default_nettype none
module swr_top
	import swr_pkg::*;
#(
	// Registration number, family code in the low byte; value is arbitrary.
	parameter logic [63:0] ROM_ID = 64'h5A00_0000_0000_0012
) (
	// Clock, reset and enable.
	input  wire logic        clk_i,
	input  wire logic        arst_n_i,
	input  wire logic        ce_i,
	// Events from the slot timing generator.
	input  wire logic        bus_reset_i,
	input  wire logic        reset_long_i,
	input  wire logic        wslot_i,
	input  wire logic        wbit_i,
	input  wire logic        rslot_i,
	// Open-drain data line.
	output logic             dq_o,
	output logic             dq_oe_o,
	output logic             presence_o,
	// Memory load port from the array side.
	input  wire logic        load_en_i,
	input  wire logic [11:0] load_addr_i,
	input  wire logic [7:0]  load_data_i,
	// Status toward the scratchpad and slot timing logic.
	output logic [15:0]      target_addr_o,
	output logic             bad_sequence_flag_o,
	output logic             resume_flag_o,
	output logic             speed_select_flag_o
);
	// All state of the command layer.
	typedef struct packed {
		swr_state_t  st;                 // Command layer state.
		logic [7:0]  rx_sr;              // Incoming bits, LSB first.
		logic [2:0]  bcnt;               // Bits received in this byte.
		logic [6:0]  cnt;                // Bit or byte counter.
		logic        miss;               // Match ROM saw a difference.
		logic        od_sel;             // Selection raises speed.
		logic [1:0]  srch_ph;            // Search triplet phase.
		logic        ext;                // Extended read in progress.
		logic [12:0] ptr;                // Read pointer.
		logic [15:0] crc;                // Page CRC accumulator.
		logic [1:0]  crc_ph;             // 0 data, 1 CRC low, 2 CRC high.
		logic [7:0]  tx_sr;              // Outgoing byte.
		logic [3:0]  tx_n;               // Bits left in outgoing byte.
		logic        pull;               // Pull line low in next read slot.
		logic        presence;           // Presence request pulse.
		logic [15:0] target_addr;        // Shared target address.
		logic        bad_sequence_flag;  // Copy is blocked while set.
		logic        resume_flag;        // Device may be resumed.
		logic        speed_select_flag;  // Overdrive speed.
	} swr_st_t;

	swr_st_t     s;        // Registered state.
	swr_st_t     n;        // Next state.
	logic [7:0]  mem [MEM_BYTES];  // Memory image.
	logic [7:0]  rx_byte;  // Byte completed by this write slot.
	logic        rx_done;  // A byte completes in this cycle.
	logic        rom_bit;  // Registration bit under search or match.
	logic [7:0]  rd_byte;  // Byte at the read pointer.
	logic        push_v;   // Byte offered to the FIFO.
	logic [7:0]  push_d;   // Byte offered.
	logic        pop;      // Serializer takes a byte.
	logic        flush;    // Discard queued bytes.
	logic [15:0] clamped;  // Received address after the clamp.

	swr_fifo_if #(.W(FIFO_WIDTH)) f ();

	swr_fifo #(
		.WIDTH (FIFO_WIDTH),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.clk_i    (clk_i),
		.arst_n_i (arst_n_i),
		.ce_i     (ce_i),
		.f        (f)
	);

	assign f.wvalid = push_v;
	assign f.wdata  = push_d;
	assign f.rready = pop;
	assign f.flush  = flush;

	// CRC16 over one byte, LSB first, reflected polynomial.
	function automatic logic [15:0] crc16_byte(input logic [15:0] c, input logic [7:0] d);
		logic [15:0] r;
		r = c;
		for (int i = 0; i < 8; i++) begin
			r = ((r[0] ^ d[i]) != 1'b0) ? ((r >> 1) ^ CRC16_POLY) : (r >> 1);
		end
		return r;
	endfunction : crc16_byte

	assign rx_byte = {wbit_i, s.rx_sr[7:1]};
	assign rx_done = wslot_i && (s.bcnt == 3'h7);
	assign rom_bit = ROM_ID[s.cnt[5:0]];
	// Past the top the memory reads as all-ones.
	assign rd_byte = ({3'h0, s.ptr} <= MEM_TOP) ? mem[s.ptr[11:0]] : FILL_BYTE;
	// Upper four bits are dropped only for addresses above the top.
	// The high byte arrives as {wbit_i, rx_sr[7:1]}, so bits 11:8 sit in rx_sr[4:1].
	assign clamped = ({wbit_i, s.rx_sr[7:1], s.target_addr[7:0]} > MEM_TOP)
		? {4'h0, s.rx_sr[4:1], s.target_addr[7:0]}
		: {wbit_i, s.rx_sr[7:1], s.target_addr[7:0]};

	// Memory image load; storage lives outside the state struct.
	always_ff @(posedge clk_i) begin
		if (ce_i && load_en_i && ({4'h0, load_addr_i} <= MEM_TOP)) begin
			mem[load_addr_i] <= load_data_i;
		end
	end

	// Next-state logic for the whole command layer.
	always_comb begin
		n          = s;
		n.presence = 1'b0;
		push_v     = 1'b0;
		push_d     = FILL_BYTE;
		pop        = 1'b0;
		flush      = 1'b0;

		// Receive shifter, LSB first.
		if (wslot_i) begin
			n.rx_sr = rx_byte;
			n.bcnt  = s.bcnt + 3'h1;
		end

		// Transmit serializer; a slot with nothing queued reads as one.
		if (s.tx_n != 4'h0) begin
			if (rslot_i) begin
				n.tx_sr = {1'b1, s.tx_sr[7:1]};
				n.tx_n  = s.tx_n - 4'h1;
			end
		end else if (f.rvalid) begin
			pop     = 1'b1;
			n.tx_sr = f.rdata;
			n.tx_n  = ROM_BYTES;
		end

		case (s.st)
			// Nothing happens before the first reset pulse.
			ST_IDLE: begin
				n.bcnt = 3'h0;
			end
			// Decode the eight-bit ROM command.
			ST_ROMCMD: begin
				if (rx_done) begin
					n.cnt    = 7'h0;
					n.miss   = 1'b0;
					n.od_sel = (rx_byte == ROM_OD_MATCH);
					case (rx_byte)
						ROM_READ:     n.st = ST_TXROM;
						ROM_MATCH:    n.st = ST_MATCH;
						ROM_OD_MATCH: n.st = ST_MATCH;
						ROM_SEARCH: begin
							n.st      = ST_SEARCH;
							n.srch_ph = 2'h0;
						end
						ROM_SKIP:     n.st = ST_MEMCMD;
						ROM_OD_SKIP: begin
							n.st                = ST_MEMCMD;
							n.speed_select_flag = 1'b1;
						end
						// Resume only the device that was last selected.
						ROM_RESUME: begin
							n.st = s.resume_flag ? ST_MEMCMD : ST_HALT;
						end
						default:      n.st = ST_HALT;
					endcase
				end
			end
			// Compare 64 received bits with the registration number.
			ST_MATCH: begin
				if (wslot_i) begin
					n.cnt = s.cnt + 7'h1;
					if (wbit_i != rom_bit) begin
						n.miss = 1'b1;
					end
					if (s.cnt == ROM_BITS - 7'h1) begin
						if (s.miss || (wbit_i != rom_bit)) begin
							// Someone else was selected, so resume must not answer.
							n.st          = ST_HALT;
							n.resume_flag = 1'b0;
						end else begin
							n.st          = ST_MEMCMD;
							n.resume_flag = 1'b1;
							if (s.od_sel) begin
								n.speed_select_flag = 1'b1;
							end
						end
					end
				end
			end
			// Search triplets: bit, complement, then the master's choice.
			ST_SEARCH: begin
				if (s.srch_ph != 2'h2) begin
					if (rslot_i) begin
						n.srch_ph = s.srch_ph + 2'h1;
					end
				end else if (wslot_i) begin
					n.srch_ph = 2'h0;
					n.cnt     = s.cnt + 7'h1;
					if (wbit_i != rom_bit) begin
						n.st          = ST_HALT;
						n.resume_flag = 1'b0;
					end else if (s.cnt == ROM_BITS - 7'h1) begin
						n.st          = ST_MEMCMD;
						n.resume_flag = 1'b1;
					end
				end
			end
			// Queue the registration number, then wait until it is sent.
			ST_TXROM: begin
				if (s.cnt[3:0] != ROM_BYTES) begin
					push_v = 1'b1;
					push_d = ROM_ID[{s.cnt[2:0], 3'h0} +: 8];
					if (f.wready) begin
						n.cnt = s.cnt + 7'h1;
					end
				end else if (!f.rvalid && s.tx_n == 4'h0) begin
					n.st   = ST_MEMCMD;
					n.bcnt = 3'h0;
				end
			end
			// Only the two read commands are served here.
			ST_MEMCMD: begin
				if (rx_done) begin
					n.cnt = 7'h0;
					n.ext = (rx_byte == MEM_READ_EXT);
					if (rx_byte == MEM_READ || rx_byte == MEM_READ_EXT) begin
						n.st = ST_ADDR;
					end else begin
						n.st = ST_HALT;
					end
				end
			end
			// Two address bytes, low first, overwriting the shared address.
			ST_ADDR: begin
				if (rx_done) begin
					n.cnt = s.cnt + 7'h1;
					if (s.cnt == 7'h0) begin
						n.target_addr[7:0] = rx_byte;
					end else begin
						n.target_addr       = clamped;
						n.ptr               = clamped[12:0];
						n.bad_sequence_flag = 1'b1;
						n.crc               = 16'h0000;
						n.crc_ph            = 2'h0;
						n.st                = ST_READ;
					end
				end
			end
			// Stream bytes; the FIFO stalls this while the master is slow.
			ST_READ: begin
				push_v = 1'b1;
				case (s.crc_ph)
					2'h1:    push_d = ~s.crc[7:0];
					2'h2:    push_d = ~s.crc[15:8];
					default: push_d = rd_byte;
				endcase
				if (f.wready) begin
					case (s.crc_ph)
						2'h1: n.crc_ph = 2'h2;
						2'h2: begin
							// Next page starts with a fresh accumulator.
							n.crc_ph = 2'h0;
							n.crc    = 16'h0000;
						end
						default: begin
							n.crc = crc16_byte(s.crc, rd_byte);
							if (s.ext && s.ptr[4:0] == PAGE_LAST) begin
								n.crc_ph = 2'h1;
							end
							if (s.ptr != 13'h1FFF) begin
								n.ptr = s.ptr + 13'h1;
							end
						end
					endcase
				end
			end
			// Deaf until the next reset pulse.
			ST_HALT: begin
				n.bcnt = 3'h0;
			end
			default: begin
				n.st = ST_IDLE;
			end
		endcase

		// A reset pulse abandons everything and asks for presence.
		if (bus_reset_i) begin
			n.st       = ST_ROMCMD;
			n.presence = 1'b1;
			n.bcnt     = 3'h0;
			n.cnt      = 7'h0;
			n.tx_n     = 4'h0;
			n.srch_ph  = 2'h0;
			n.crc_ph   = 2'h0;
			pop        = 1'b0;
			push_v     = 1'b0;
			flush      = 1'b1;
			if (reset_long_i) begin
				n.speed_select_flag = 1'b0;
			end
		end

		// Line drive for the next read slot: low only, never high.
		if (n.st == ST_SEARCH && n.srch_ph != 2'h2) begin
			n.pull = (n.srch_ph == 2'h0) ? !ROM_ID[n.cnt[5:0]] : ROM_ID[n.cnt[5:0]];
		end else begin
			n.pull = (n.tx_n != 4'h0) && !n.tx_sr[0];
		end
	end

	// State register, frozen while the enable is low.
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			s    <= '0;
			s.st <= ST_IDLE;
		end else if (ce_i) begin
			s <= n;
		end
	end

	// The pin is open-drain: its output level is tied low.
	assign dq_o                = 1'b0;
	assign dq_oe_o             = s.pull;
	assign presence_o          = s.presence;
	assign target_addr_o       = s.target_addr;
	assign bad_sequence_flag_o = s.bad_sequence_flag;
	assign resume_flag_o       = s.resume_flag;
	assign speed_select_flag_o = s.speed_select_flag;

	a_open_drain: assert property (
		@(posedge clk_i) disable iff (!arst_n_i) dq_o == 1'b0)
		else $error("data line driven high");

	a_reset_abort: assert property (
		@(posedge clk_i) disable iff (!arst_n_i)
		ce_i && bus_reset_i |=> s.st == ST_ROMCMD && s.tx_n == 4'h0 && !f.rvalid)
		else $error("reset pulse did not abandon transaction");

	a_presence_pulse: assert property (
		@(posedge clk_i) disable iff (!arst_n_i)
		ce_i && bus_reset_i |=> presence_o ##1 (!presence_o || $past(bus_reset_i)))
		else $error("presence pulse missing or stuck");

	a_read_bad_seq: assert property (
		@(posedge clk_i) disable iff (!arst_n_i)
		$rose(s.st == ST_READ) |-> bad_sequence_flag_o && target_addr_o[12:0] == s.ptr)
		else $error("read entered without bad sequence flag");

	a_clamp_addr: assert property (
		@(posedge clk_i) disable iff (!arst_n_i)
		ce_i && s.st == ST_ADDR && rx_done && s.cnt == 7'h1 && !bus_reset_i
		|=> target_addr_o == {4'h0, $past(rx_byte[3:0]), $past(s.target_addr[7:0])})
		else $error("target address not clamped");

	a_past_end_ones: assert property (
		@(posedge clk_i) disable iff (!arst_n_i)
		s.st == ST_READ && s.crc_ph == 2'h0 && {3'h0, s.ptr} > MEM_TOP |-> push_d == FILL_BYTE)
		else $error("read past top not all-ones");

	a_page_crc: assert property (
		@(posedge clk_i) disable iff (!arst_n_i)
		ce_i && !bus_reset_i && s.st == ST_READ && s.ext && s.crc_ph == 2'h0
		&& s.ptr[4:0] == PAGE_LAST && f.wready
		|=> s.crc_ph == 2'h1 && push_d == ~s.crc[7:0])
		else $error("page CRC not appended");

	a_resume_gate: assert property (
		@(posedge clk_i) disable iff (!arst_n_i)
		ce_i && !bus_reset_i && s.st == ST_ROMCMD && rx_done && rx_byte == ROM_RESUME
		|=> s.st == (($past(s.resume_flag)) ? ST_MEMCMD : ST_HALT))
		else $error("resume not gated by resume flag");

	a_search_drop: assert property (
		@(posedge clk_i) disable iff (!arst_n_i)
		ce_i && !bus_reset_i && s.st == ST_SEARCH && s.srch_ph == 2'h2 && wslot_i
		&& wbit_i != rom_bit |=> s.st == ST_HALT && !resume_flag_o)
		else $error("search mismatch did not drop out");

	a_skip_direct: assert property (
		@(posedge clk_i) disable iff (!arst_n_i)
		ce_i && !bus_reset_i && s.st == ST_ROMCMD && rx_done && rx_byte == ROM_SKIP
		|=> s.st == ST_MEMCMD && $stable(resume_flag_o))
		else $error("skip did not go to memory commands");
endmodule : swr_top
`default_nettype wire

/* dv/swr_master_model.sv */
/*
 * Bus master model: reset pulses, write slots and read slots.
 * Assumes the design's slot event ports, sampled on the rising clock.
 */
`timescale 1ns/1ps
`default_nettype none
module swr_master_model (
	// Clock and line state.
	input  wire logic clk_i,
	input  wire logic dq_oe_i,
	// Slot events toward the device.
	output var  logic bus_reset_o,
	output var  logic reset_long_o,
	output var  logic wslot_o,
	output var  logic wbit_o,
	output var  logic rslot_o
);
	// Between slots no event is pending, so the line rests high.
	initial begin
		{bus_reset_o, reset_long_o, wslot_o, wbit_o, rslot_o} = 5'h00;
	end

	// One slot, then recovery so that the next bit can settle.
	task automatic slot(input logic rd, input logic wb, output logic rb);
		@(negedge clk_i);
		rb = !dq_oe_i; // A pulled-low line reads as zero.
		rslot_o = rd;
		wslot_o = !rd;
		wbit_o = wb;
		@(negedge clk_i);
		rslot_o = 1'b0;
		wslot_o = 1'b0;
		wbit_o = !wb; // Released data must not keep its last value.
		repeat (3) @(negedge clk_i);
	endtask : slot

	// Reset pulse; returns in the cycle where presence is due.
	task automatic bus_reset(input logic long_rst);
		@(negedge clk_i);
		bus_reset_o = 1'b1;
		reset_long_o = long_rst;
		@(negedge clk_i);
		// Presence stands only this one cycle, so the caller samples it now.
		bus_reset_o = 1'b0;
		reset_long_o = !long_rst;
	endtask : bus_reset

	// Bytes travel least significant bit first.
	task automatic wbyte(input logic [7:0] b);
		logic d;
		for (int i = 0; i < 8; i++) slot(1'b0, b[i], d);
	endtask : wbyte

	task automatic rbyte(output logic [7:0] b);
		logic r;
		for (int i = 0; i < 8; i++) begin
			slot(1'b1, 1'b1, r);
			b[i] = r;
		end
	endtask : rbyte
endmodule : swr_master_model
`default_nettype wire

/* dv/test_single_wire_rom_and_read_memory.sv */
/*
 * Self-checking bench: the master model drives slots, a queue model
 * predicts every byte of each memory read. Assumes one 25 MHz clock.
 */
`timescale 1ns/1ps
`default_nettype none
module test_single_wire_rom_and_read_memory;
	import swr_pkg::*;
	localparam logic [63:0] ID = 64'h3C00_1234_5678_9A28; // Arbitrary value.
	logic        clk_i = 1'b0, arst_n_i = 1'b0, ce_i = 1'b0, load_en_i = 1'b0;
	logic [11:0] load_addr_i = 12'h000;
	logic [7:0]  load_data_i = 8'h00;
	logic        bus_rst, rst_long, wslot, wbit, rslot, dq, dq_oe, presence, bsf, rcf, odf;
	logic [15:0] taddr;
	logic [7:0]  mem [MEM_BYTES]; // Copy of the array image.
	int          bad_count = 0, n_tests = 0;

	always #20 clk_i = ~clk_i;

	swr_top #(.ROM_ID(ID)) swr_top_inst (.clk_i(clk_i), .arst_n_i(arst_n_i), .ce_i(ce_i),
		.bus_reset_i(bus_rst), .reset_long_i(rst_long), .wslot_i(wslot), .wbit_i(wbit),
		.rslot_i(rslot), .dq_o(dq), .dq_oe_o(dq_oe), .presence_o(presence),
		.load_en_i(load_en_i), .load_addr_i(load_addr_i), .load_data_i(load_data_i),
		.target_addr_o(taddr), .bad_sequence_flag_o(bsf), .resume_flag_o(rcf),
		.speed_select_flag_o(odf));
	swr_master_model swr_master_model_inst (.clk_i(clk_i), .dq_oe_i(dq_oe),
		.bus_reset_o(bus_rst), .reset_long_o(rst_long), .wslot_o(wslot), .wbit_o(wbit),
		.rslot_o(rslot));

	task automatic check(input logic [63:0] seen, input logic [63:0] exp);
		n_tests++;
		if (seen !== exp) begin
			bad_count++;
			$display("[FAIL] %0t: saw %h, expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic stop_test();
		$display("Checks %0d, mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : stop_test

	// A hang counts as a mismatch.
	initial begin
		repeat (100000) @(posedge clk_i);
		bad_count++;
		stop_test();
	end

	function automatic logic [15:0] crc16(input logic [15:0] c, input logic [7:0] d);
		c ^= {8'h00, d};
		for (int i = 0; i < 8; i++) c = c[0] ? ((c >> 1) ^ CRC16_POLY) : (c >> 1);
		return c;
	endfunction : crc16

	task automatic wb(input logic [7:0] b);
		swr_master_model_inst.wbyte(b);
	endtask : wb

	task automatic start(input logic [7:0] cmd, input logic long_rst);
		swr_master_model_inst.bus_reset(long_rst);
		check(presence, 1'b1);
		wb(cmd);
	endtask : start

	task automatic send_id(input logic [63:0] v);
		for (int k = 0; k < 8; k++) wb(v[8*k +: 8]);
	endtask : send_id

	// Memory read with the expected stream built as a queue.
	task automatic mread(input logic [7:0] cmd, input logic [15:0] addr, input int n);
		logic [7:0]  q [$];
		logic [7:0]  b;
		logic [15:0] crc;
		int          p;
		crc = 16'h0000;
		p = (addr > MEM_TOP) ? int'(addr[11:0]) : int'(addr);
		wb(cmd);
		wb(addr[7:0]);
		wb(addr[15:8]);
		check(taddr, 16'(p));
		check(bsf, 1'b1);
		while (q.size() < n) begin
			b = (p > MEM_TOP) ? FILL_BYTE : mem[p];
			q.push_back(b);
			crc = crc16(crc, b);
			if (cmd == MEM_READ_EXT && p[4:0] == PAGE_LAST) begin
				q.push_back(~crc[7:0]);
				q.push_back(~crc[15:8]);
				crc = 16'h0000;
			end
			p++;
		end
		foreach (q[i]) begin
			swr_master_model_inst.rbyte(b);
			check(b, q[i]);
		end
	endtask : mread

	initial begin
		logic [7:0] b;
		logic       x, y;
		void'($urandom(37));
		repeat (2) @(negedge clk_i);
		arst_n_i = 1'b1;
		ce_i = 1'b1;
		for (int a = 0; a < MEM_BYTES; a++) begin
			@(negedge clk_i);
			mem[a] = 8'($urandom);
			load_en_i = 1'b1;
			load_addr_i = 12'(a);
			load_data_i = mem[a];
		end
		@(negedge clk_i);
		load_en_i = 1'b0;
		start(ROM_READ, 1'b0);
		for (int k = 0; k < 8; k++) begin
			swr_master_model_inst.rbyte(b);
			check(b, ID[8*k +: 8]);
		end
		mread(MEM_READ, 16'($urandom_range(32'h0A3F)), 3);
		start(ROM_SKIP, 1'b0);
		mread(MEM_READ, 16'hFA3E, 4);
		start(ROM_MATCH, 1'b0);
		send_id(ID);
		check(rcf, 1'b1);
		// A frozen stretch with no slots must leave the selection in place.
		ce_i = 1'b0;
		repeat (3) @(negedge clk_i);
		check(rcf, 1'b1);
		ce_i = 1'b1;
		mread(MEM_READ_EXT, 16'h001E, 5);
		for (int i = 0; i < 3; i++) swr_master_model_inst.slot(1'b1, 1'b1, x);
		start(ROM_RESUME, 1'b0);
		mread(MEM_READ_EXT, 16'h0A3F, 5);
		start(ROM_MATCH, 1'b0);
		send_id(ID ^ 64'h0000_0100_0000_0000);
		check(rcf, 1'b0);
		swr_master_model_inst.rbyte(b);
		check(b, 8'hFF);
		start(ROM_RESUME, 1'b0);
		wb(MEM_READ);
		wb(8'h00);
		wb(8'h00);
		swr_master_model_inst.rbyte(b);
		check(b, 8'hFF);
		start(ROM_SEARCH, 1'b0);
		for (int i = 0; i < 64; i++) begin
			swr_master_model_inst.slot(1'b1, 1'b1, x);
			swr_master_model_inst.slot(1'b1, 1'b1, y);
			check({x, y}, {ID[i], !ID[i]});
			swr_master_model_inst.slot(1'b0, ID[i], x);
		end
		check(rcf, 1'b1);
		mread(MEM_READ, 16'h0005, 1);
		start(ROM_OD_SKIP, 1'b0);
		check(odf, 1'b1);
		mread(MEM_READ, 16'h0007, 1);
		start(ROM_SKIP, 1'b0);
		check(odf, 1'b1);
		start(ROM_OD_MATCH, 1'b1);
		check(odf, 1'b0);
		send_id(ID);
		check(odf, 1'b1);
		check(dq, 1'b0);
		stop_test();
	end
endmodule : test_single_wire_rom_and_read_memory
`default_nettype wire
